// >>> rtl/urhpc_pkg.sv
// Constants and types for the root hub port status and control block.
// Assumes one 250 MHz clock and the word-wide I/O register port of the controller.

package urhpc_pkg;

  localparam int NPORT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] PORT1_OFS = 8'h10;
  localparam logic [7:0] PORT2_OFS = 8'h12;
  localparam logic [15:0] PSC_RST = 16'h0000;

  localparam int B_CON = 0;
  localparam int B_CONCHG = 1;
  localparam int B_EN = 2;
  localparam int B_ENCHG = 3;
  localparam int B_LINE_LO = 4;
  localparam int B_RESDET = 6;
  localparam int B_RSVD_ONE = 7;
  localparam int B_LS = 8;
  localparam int B_PRST = 9;
  localparam int B_SUS = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_KHZ = 250000;
  localparam int FS_KHZ = 12000;
  localparam int LS_KHZ = 1500;
  localparam int ATTACH_BITS = 64;
  localparam int EOP_BITS = 2;
  // Pin synchroniser delay comes out of the attach budget
  localparam int SYNC_CYC = 4;
  // Longest time: round down
  localparam int ATTACH_CYC = ATTACH_BITS * CLK_KHZ / FS_KHZ;
  // Least time: round up
  localparam int EOP_CYC = (EOP_BITS * CLK_KHZ + LS_KHZ - 1) / LS_KHZ;
  localparam logic [10:0] ATTACH_CNT = 11'(ATTACH_CYC - SYNC_CYC - 1);
  localparam logic [10:0] EOP_CNT = 11'(EOP_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    DRV_IDLE = 2'b00,
    DRV_RESET = 2'b01,
    DRV_RESUME = 2'b10,
    DRV_EOP = 2'b11
  } urhpc_drv_e;

  typedef struct packed {
    logic con;
    logic conchg;
    logic en;
    logic enchg;
    logic sus;
    logic prst;
    logic ls;
    logic resdet;
    logic [1:0] linest;
    logic sus_pend;
    logic en_pend;
    logic en_req;
    logic eop;
    logic [10:0] cnt;
    logic [10:0] eop_cnt;
    logic [1:0] prev;
    urhpc_drv_e drv;
    logic pdp;
    logic pdm;
    logic poe;
    logic blk;
  } urhpc_port_s;

endpackage

// >>> rtl/urhpc_line_sync.sv
// Three-stage synchroniser for the D+ and D- levels of one port.
// Assumes asynchronous pin levels; output moves once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none

module urhpc_line_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pin levels
  input wire logic i_dp,
  input wire logic i_dm,
  // Agreed levels
  output logic o_dp,
  output logic o_dm
);

  typedef struct packed {
    logic [2:0] dp_sh;
    logic [2:0] dm_sh;
    logic dp;
    logic dm;
  } urhpc_sync_s;

  urhpc_sync_s s_q;
  urhpc_sync_s s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.dp_sh = {s_q.dp_sh[1:0], i_dp};
    s_d.dm_sh = {s_q.dm_sh[1:0], i_dm};
    if (s_q.dp_sh[1] == s_q.dp_sh[2])
    begin
      s_d.dp = s_q.dp_sh[2];
    end
    if (s_q.dm_sh[1] == s_q.dm_sh[2])
    begin
      s_d.dm = s_q.dm_sh[2];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_dp = s_q.dp;
  assign o_dm = s_q.dm;

endmodule

`default_nettype wire

// >>> rtl/urhpc_top.sv
// Root hub port status and control registers for two downstream ports.
// Assumes the frame logic gives the EOF2 strobe, fault flags and a busy level.
`timescale 1ns/10ps
`default_nettype none

module urhpc_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // I/O register port
  input wire logic i_io_sel,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  input wire logic [7:0] i_io_addr,
  input wire logic [1:0] i_io_be,
  input wire logic [15:0] i_io_wdata,
  output logic [15:0] o_io_rdata,
  // Controller state
  input wire logic i_global_suspend,
  input wire logic i_eof2,
  input wire logic i_xact_busy,
  input wire logic [urhpc_pkg::NPORT-1:0] i_port_fault,
  output logic o_resume_sig,
  // Port lines
  input wire logic [urhpc_pkg::NPORT-1:0] i_dp,
  input wire logic [urhpc_pkg::NPORT-1:0] i_dm,
  output logic [urhpc_pkg::NPORT-1:0] o_dp,
  output logic [urhpc_pkg::NPORT-1:0] o_dm,
  output logic [urhpc_pkg::NPORT-1:0] o_oe,
  output logic [urhpc_pkg::NPORT-1:0] o_block
);

  import urhpc_pkg::*;

  typedef struct packed {
    urhpc_port_s [NPORT-1:0] port;
    logic [15:0] rdata;
    logic resume;
  } urhpc_state_s;

  urhpc_state_s s_q;
  urhpc_state_s s_d;
  logic [NPORT-1:0] lin_dp;
  logic [NPORT-1:0] lin_dm;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addr_hit(input logic [7:0] addr, input int p);
    addr_hit = (p == 0) ? (addr == PORT1_OFS) : (addr == PORT2_OFS);
  endfunction

  // K is D- high for full speed, D+ high for low speed
  function automatic logic line_k(input logic ls, input logic dp, input logic dm);
    line_k = ls ? (dp & ~dm) : (~dp & dm);
  endfunction

  function automatic logic [15:0] pack_reg(input urhpc_port_s ps);
    logic [15:0] r;
    r = PSC_RST;
    r[B_CON] = ps.con;
    r[B_CONCHG] = ps.conchg;
    r[B_EN] = ps.en;
    r[B_ENCHG] = ps.enchg;
    r[B_LINE_LO +: 2] = ps.linest;
    r[B_RESDET] = ps.resdet;
    r[B_RSVD_ONE] = 1'b1;
    r[B_LS] = ps.ls;
    r[B_PRST] = ps.prst;
    r[B_SUS] = ps.sus;
    pack_reg = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Line synchronisers, one per port

  for (genvar g = 0; g < NPORT; g++)
  begin : g_sync
    urhpc_line_sync u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_dp(i_dp[g]),
      .i_dm(i_dm[g]),
      .o_dp(lin_dp[g]),
      .o_dm(lin_dm[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic wr_hit;
    logic present;
    logic rise_any;
    wr_hit = 1'b0;
    present = 1'b0;
    rise_any = 1'b0;
    s_d = s_q;
    s_d.resume = 1'b0;
    // Each port runs from its own slice only
    for (int p = 0; p < NPORT; p++)
    begin
      // Byte writes are dropped; reserved bits are never stored
      wr_hit = i_io_sel && i_io_wr && (i_io_be == 2'b11) && addr_hit(i_io_addr, p);
      if (wr_hit)
      begin
        if (i_io_wdata[B_CONCHG])
        begin
          s_d.port[p].conchg = 1'b0;
        end
        if (i_io_wdata[B_ENCHG])
        begin
          s_d.port[p].enchg = 1'b0;
        end
        s_d.port[p].prst = i_io_wdata[B_PRST];
        s_d.port[p].en_req = i_io_wdata[B_EN];
        s_d.port[p].en_pend = (i_io_wdata[B_EN] != s_q.port[p].en);
        if (i_io_wdata[B_SUS])
        begin
          s_d.port[p].sus_pend = ~s_q.port[p].sus;
        end
        else
        begin
          s_d.port[p].sus = 1'b0;
          s_d.port[p].sus_pend = 1'b0;
        end
        if (i_io_wdata[B_RESDET])
        begin
          s_d.port[p].resdet = 1'b1;
        end
        else if (s_q.port[p].resdet && !s_q.port[p].eop)
        begin
          s_d.port[p].eop = 1'b1;
          s_d.port[p].eop_cnt = '0;
        end
      end
      // Enable changes and suspend entry wait for the bus transaction to finish
      if (!i_xact_busy)
      begin
        if (s_d.port[p].en_pend)
        begin
          s_d.port[p].en = s_d.port[p].en_req;
          s_d.port[p].en_pend = 1'b0;
        end
        if (s_d.port[p].sus_pend)
        begin
          s_d.port[p].sus = s_d.port[p].en;
          s_d.port[p].sus_pend = 1'b0;
        end
      end
      if (!s_d.port[p].en)
      begin
        s_d.port[p].sus = 1'b0;
      end
      // Attach and detach debounce; ignored while we drive the lines
      present = lin_dp[p] | lin_dm[p];
      if (s_q.port[p].poe || present == s_q.port[p].con)
      begin
        s_d.port[p].cnt = '0;
      end
      else if (s_q.port[p].cnt == ATTACH_CNT)
      begin
        s_d.port[p].cnt = '0;
        s_d.port[p].con = present;
        s_d.port[p].conchg = 1'b1;
        if (present)
        begin
          s_d.port[p].ls = lin_dm[p] & ~lin_dp[p];
        end
        else
        begin
          if (s_q.port[p].en)
          begin
            s_d.port[p].enchg = 1'b1;
          end
          s_d.port[p].en = 1'b0;
          s_d.port[p].en_pend = 1'b0;
          s_d.port[p].sus = 1'b0;
          s_d.port[p].sus_pend = 1'b0;
        end
      end
      else
      begin
        s_d.port[p].cnt = s_q.port[p].cnt + 11'h001;
      end
      if (i_eof2)
      begin
        s_d.port[p].linest = {lin_dm[p], lin_dp[p]};
        if (s_q.port[p].en && i_port_fault[p])
        begin
          s_d.port[p].en = 1'b0;
          s_d.port[p].sus = 1'b0;
          s_d.port[p].enchg = 1'b1;
        end
      end
      // Remote wakeup seen as J then K while suspended
      if (s_q.port[p].sus && line_k(~s_q.port[p].ls, s_q.port[p].prev[0], s_q.port[p].prev[1])
          && line_k(s_q.port[p].ls, lin_dp[p], lin_dm[p]))
      begin
        s_d.port[p].resdet = 1'b1;
      end
      s_d.port[p].prev = {lin_dm[p], lin_dp[p]};
      if (s_d.port[p].prst)
      begin
        s_d.port[p].en = 1'b0;
        s_d.port[p].en_pend = 1'b0;
        s_d.port[p].sus = 1'b0;
        s_d.port[p].sus_pend = 1'b0;
      end
      if (s_q.port[p].eop)
      begin
        if (s_q.port[p].eop_cnt == EOP_CNT)
        begin
          s_d.port[p].eop = 1'b0;
          s_d.port[p].resdet = 1'b0;
        end
        else
        begin
          s_d.port[p].eop_cnt = s_q.port[p].eop_cnt + 11'h001;
        end
      end
      // Line driver; reset outranks EOP, EOP outranks K
      if (s_d.port[p].prst)
      begin
        s_d.port[p].drv = DRV_RESET;
      end
      else if (s_d.port[p].eop)
      begin
        s_d.port[p].drv = DRV_EOP;
      end
      else if (s_d.port[p].resdet && s_d.port[p].sus)
      begin
        s_d.port[p].drv = DRV_RESUME;
      end
      else
      begin
        s_d.port[p].drv = DRV_IDLE;
      end
      s_d.port[p].poe = (s_d.port[p].drv != DRV_IDLE);
      s_d.port[p].pdp = (s_d.port[p].drv == DRV_RESUME) && s_d.port[p].ls;
      s_d.port[p].pdm = (s_d.port[p].drv == DRV_RESUME) && !s_d.port[p].ls;
      s_d.port[p].blk = s_d.port[p].sus;
      rise_any = rise_any | (s_d.port[p].resdet & ~s_q.port[p].resdet)
        | (s_d.port[p].enchg & ~s_q.port[p].enchg) | (s_d.port[p].conchg & ~s_q.port[p].conchg);
    end
    s_d.resume = i_global_suspend & rise_any;
    if (i_io_sel && i_io_rd)
    begin
      if (addr_hit(i_io_addr, 0))
      begin
        s_d.rdata = pack_reg(s_q.port[0]);
      end
      else if (addr_hit(i_io_addr, 1))
      begin
        s_d.rdata = pack_reg(s_q.port[1]);
      end
      else
      begin
        s_d.rdata = '0;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_io_rdata = s_q.rdata;
  assign o_resume_sig = s_q.resume;
  for (genvar g = 0; g < NPORT; g++)
  begin : g_out
    assign o_dp[g] = s_q.port[g].pdp;
    assign o_dm[g] = s_q.port[g].pdm;
    assign o_oe[g] = s_q.port[g].poe;
    assign o_block[g] = s_q.port[g].blk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  for (genvar g = 0; g < NPORT; g++)
  begin : g_chk
    reset_state_a: assert property (@(posedge i_clk) $rose(i_rst_n) |->
      !s_q.port[g].con && !s_q.port[g].en && s_q.port[g].linest == 2'b00)
      else $error("port not idle after reset");

    attach_time_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_q.port[g].cnt == ATTACH_CNT && !s_q.port[g].poe && (lin_dp[g] | lin_dm[g]) != s_q.port[g].con
      |=> $changed(s_q.port[g].con) && s_q.port[g].conchg && s_q.port[g].cnt == 11'h000)
      else $error("attach not flagged at debounce end");

    resume_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(s_q.port[g].conchg) && $past(i_global_suspend) |-> o_resume_sig)
      else $error("no resume on change in global suspend");

    state_code_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_q.port[g].sus |-> s_q.port[g].en && s_q.port[g].blk)
      else $error("suspend without enable");

    suspend_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(s_q.port[g].sus) |-> !$past(i_xact_busy))
      else $error("suspend entered during transaction");

    reset_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_q.port[g].prst |-> !s_q.port[g].en && o_oe[g] && !o_dp[g] && !o_dm[g])
      else $error("port reset not driving SE0");

    resume_k_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_q.port[g].resdet && s_q.port[g].sus && !s_q.port[g].eop && !s_q.port[g].prst
      |-> o_oe[g] && o_dp[g] == s_q.port[g].ls && o_dm[g] == !s_q.port[g].ls)
      else $error("resume K not driven");

    eop_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(s_q.port[g].eop) && !s_q.port[g].prst |-> s_q.port[g].resdet [*8] ##0 o_oe[g])
      else $error("resume bit dropped before EOP end");

    enchg_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_q.port[g].enchg && i_io_sel && i_io_wr && i_io_be == 2'b11 && addr_hit(i_io_addr, g)
      && !i_io_wdata[B_ENCHG] |=> s_q.port[g].enchg)
      else $error("enable change lost on write zero");

    en_only_sw_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(s_q.port[g].en) |-> $past(s_q.port[g].en_pend) && $past(s_q.port[g].en_req) || $past(s_d.port[g].en_req))
      else $error("enable set without software");
  end

  read_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_io_sel && i_io_rd && (i_io_addr == PORT1_OFS || i_io_addr == PORT2_OFS) |=> o_io_rdata[B_RSVD_ONE])
    else $error("reserved bit 7 read as zero");

endmodule

`default_nettype wire

// >>> verification/urhpc_dev_model.sv
// USB device model on both downstream ports: attach, speed and K signalling.
// Assumes the bench changes its controls off the rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module urhpc_dev_model (
  // Host side of each pair
  input wire logic [urhpc_pkg::NPORT-1:0] i_oe,
  input wire logic [urhpc_pkg::NPORT-1:0] i_hdp,
  input wire logic [urhpc_pkg::NPORT-1:0] i_hdm,
  // Device controls
  input wire logic [urhpc_pkg::NPORT-1:0] i_attached,
  input wire logic [urhpc_pkg::NPORT-1:0] i_low,
  input wire logic [urhpc_pkg::NPORT-1:0] i_kstate,
  // Resolved wire levels
  output logic [urhpc_pkg::NPORT-1:0] o_dp,
  output logic [urhpc_pkg::NPORT-1:0] o_dm
);
  import urhpc_pkg::*;

  logic [NPORT-1:0] dev_dp;

  // Host pull-downs leave an empty port at SE0; a low-speed J looks like a full-speed K
  assign dev_dp = i_attached & ~(i_low ^ i_kstate);
  // The host wins the pair whenever it drives
  assign o_dp = (i_oe & i_hdp) | (~i_oe & dev_dp);
  assign o_dm = (i_oe & i_hdm) | (~i_oe & i_attached & ~dev_dp);
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the two-port root hub status and control registers.
// Assumes the device model drives the port lines and the bench plays host software.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import urhpc_pkg::*;

  logic i_clk;
  logic i_rst_n;
  logic io_sel;
  logic io_rd;
  logic io_wr;
  logic gsus;
  logic eof2;
  logic busy;
  logic resume;
  logic [7:0] io_addr;
  logic [1:0] io_be;
  logic [15:0] io_wdata;
  logic [15:0] rdata;
  logic [1:0] fault;
  logic [1:0] dp;
  logic [1:0] dm;
  logic [1:0] hdp;
  logic [1:0] hdm;
  logic [1:0] oe;
  logic [1:0] blk;
  logic [1:0] att;
  logic [1:0] low;
  logic [1:0] kst;
  logic [3:0] pins0;
  logic [3:0] pins1;
  int bad_count;
  int checks;
  int cycles;
  int resumes;

  assign pins0 = {blk[0], oe[0], hdp[0], hdm[0]};
  assign pins1 = {blk[1], oe[1], hdp[1], hdm[1]};

  urhpc_top i_urhpc_top (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_io_sel(io_sel), .i_io_rd(io_rd), .i_io_wr(io_wr),
    .i_io_addr(io_addr), .i_io_be(io_be), .i_io_wdata(io_wdata), .o_io_rdata(rdata),
    .i_global_suspend(gsus), .i_eof2(eof2), .i_xact_busy(busy), .i_port_fault(fault),
    .o_resume_sig(resume), .i_dp(dp), .i_dm(dm), .o_dp(hdp), .o_dm(hdm), .o_oe(oe), .o_block(blk)
  );

  urhpc_dev_model i_urhpc_dev_model (
    .i_oe(oe), .i_hdp(hdp), .i_hdm(hdm), .i_attached(att), .i_low(low), .i_kstate(kst),
    .o_dp(dp), .o_dm(dm)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d, bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask

  // One word access; the extra edge lets a write land before the next access
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(negedge i_clk);
    io_sel = 1'b1;
    io_wr = w;
    io_rd = ~w;
    io_addr = a;
    io_be = be;
    io_wdata = d;
    @(negedge i_clk);
    io_sel = 1'b0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    @(negedge i_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 2'b11);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000, 2'b11);
    chk(rdata, e);
  endtask

  // Bounded by the attach time plus synchroniser and read latency
  task automatic poll(input logic [7:0] a, input logic [15:0] m, input logic [15:0] v);
    int n;
    bus(1'b0, a, 16'h0000, 2'b11);
    for (n = 3; n < ATTACH_CYC + 16 && (rdata & m) !== v; n += 3)
      bus(1'b0, a, 16'h0000, 2'b11);
    chk(rdata & m, v);
  endtask

  task automatic strobe();
    @(negedge i_clk);
    eof2 = 1'b1;
    @(negedge i_clk);
    eof2 = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always #2 i_clk = ~i_clk;

  // Sampled off the launching edge so the resume pulse is settled
  always @(negedge i_clk)
  begin
    cycles++;
    if (resume === 1'b1)
      resumes++;
    if (cycles == 12000)
    begin
      bad_count++;
      $display("unexpected at %0t: run too long", $time);
      conclude();
    end
  end

  initial
  begin
    {i_clk, i_rst_n, io_sel, io_rd, io_wr, gsus, eof2, busy} = 8'h00;
    {io_addr, io_be, io_wdata, fault, att, low, kst} = 34'h0;
    {bad_count, checks, cycles, resumes} = {4{32'h0}};
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    rd(PORT1_OFS, 16'h0080);
    rd(PORT2_OFS, 16'h0080);
    rd(8'h14, 16'h0000);
    chk({12'h0, pins0}, 16'h0000);
    // Full-speed attach on port one
    att[0] = 1'b1;
    poll(PORT1_OFS, 16'h0001, 16'h0001);
    rd(PORT1_OFS, 16'h0083);
    rd(PORT2_OFS, 16'h0080);
    strobe();
    rd(PORT1_OFS, 16'h0093);
    wr(PORT1_OFS, 16'h0002);
    rd(PORT1_OFS, 16'h0091);
    wr(PORT1_OFS, 16'h0004);
    rd(PORT1_OFS, 16'h0095);
    bus(1'b1, PORT1_OFS, 16'h0000, 2'b01);
    rd(PORT1_OFS, 16'h0095);
    // Suspend held off by a transaction in flight
    busy = 1'b1;
    wr(PORT1_OFS, 16'h1004);
    rd(PORT1_OFS, 16'h0095);
    chk({12'h0, pins0}, 16'h0000);
    busy = 1'b0;
    repeat (4) @(negedge i_clk);
    rd(PORT1_OFS, 16'h1095);
    chk({12'h0, pins0}, 16'h0008);
    // Remote wakeup while the controller sleeps
    gsus = 1'b1;
    kst[0] = 1'b1;
    poll(PORT1_OFS, 16'h0040, 16'h0040);
    kst[0] = 1'b0;
    chk({12'h0, pins0}, 16'h000d);
    chk(16'(resumes), 16'h0001);
    gsus = 1'b0;
    wr(PORT1_OFS, 16'h1004);
    rd(PORT1_OFS, 16'h10d5);
    chk({12'h0, pins0}, 16'h000c);
    repeat (EOP_CYC) @(negedge i_clk);
    rd(PORT1_OFS, 16'h1095);
    chk({12'h0, pins0}, 16'h0008);
    wr(PORT1_OFS, 16'h0004);
    rd(PORT1_OFS, 16'h0095);
    // Port reset, held and released by software
    wr(PORT1_OFS, 16'h0200);
    rd(PORT1_OFS, 16'h0291);
    chk({12'h0, pins0}, 16'h0004);
    wr(PORT1_OFS, 16'h0000);
    rd(PORT1_OFS, 16'h0091);
    // Enable waits for the bus, then a fault at EOF2 disables
    busy = 1'b1;
    wr(PORT1_OFS, 16'h0004);
    rd(PORT1_OFS, 16'h0091);
    busy = 1'b0;
    repeat (4) @(negedge i_clk);
    rd(PORT1_OFS, 16'h0095);
    fault[0] = 1'b1;
    strobe();
    fault[0] = 1'b0;
    rd(PORT1_OFS, 16'h0099);
    wr(PORT1_OFS, 16'h0000);
    rd(PORT1_OFS, 16'h0099);
    wr(PORT1_OFS, 16'h0008);
    rd(PORT1_OFS, 16'h0091);
    // Low-speed attach on port two
    att[1] = 1'b1;
    low[1] = 1'b1;
    poll(PORT2_OFS, 16'h0001, 16'h0001);
    rd(PORT2_OFS, 16'h0183);
    wr(PORT2_OFS, 16'h0002);
    rd(PORT2_OFS, 16'h0181);
    // Software resume on a suspended low-speed port
    wr(PORT2_OFS, 16'h0004);
    wr(PORT2_OFS, 16'h1004);
    wr(PORT2_OFS, 16'h1044);
    chk({12'h0, pins1}, 16'h000e);
    wr(PORT2_OFS, 16'h0004);
    chk({12'h0, pins1}, 16'h0004);
    repeat (EOP_CYC) @(negedge i_clk);
    rd(PORT2_OFS, 16'h0185);
    chk({12'h0, pins1}, 16'h0000);
    rd(PORT1_OFS, 16'h0091);
    // Disconnect of an enabled port
    wr(PORT1_OFS, 16'h0004);
    att[0] = 1'b0;
    poll(PORT1_OFS, 16'h0001, 16'h0000);
    rd(PORT1_OFS, 16'h009a);
    chk(16'(resumes), 16'h0001);
    conclude();
  end
endmodule
`default_nettype wire
